// file: verilog/mgo_regs.svh
// Register offsets, field positions, reset values and timing counts of the
// mute, gain and offset control block. Assumes a 7-bit effective sub-address.
//
// Overview of operation
// R01 - Reset pin low returns registers 00h-6Fh and 80h-EFh to defaults.
// R02 - Registers 70h-7Fh and F0h-FFh keep their values through the reset pin.
// R03 - Fault pin driven high or low forces hard mute; floating means no mute.
// R04 - With auto-release set, fault mute ends when the fault pin is released.
// R05 - Without auto-release, fault mute holds until release plus latch-clear rising.
// R06 - Hard mute bit falling from one to zero starts offset calibration.
// R07 - Calibration ends within 1 s without tracking pre-gain, 4 s with it.
// R08 - With tracking pre-gain, each of four pre-gain levels is calibrated.
// R09 - Ten-bit offset per channel stored, in-use values readable at 02h-09h.
// R10 - Four offsets per channel kept; readback follows the selected pre-gain.
// R11 - Register 3Dh bit 7 enables volume-tracking pre-gain.
// R12 - With tracking pre-gain off, pre-gain stays at full gain.
// R13 - Volume FFh-F4h full, F3h-E8h half, E7h-DCh quarter, below eighth.
// R14 - Post-gain select zero gives low post-gain, one gives 25% higher gain.
// R15 - Bank select one uses bank offset, zero uses internal calibration.
// R16 - Software calibrates low post-gain, copies readback to bank, then high.
// R17 - Software changes post-gain only while pre-gain is one eighth.
// R18 - Software keeps fault latched and clocks steady during bank swapping.
// R19 - Effective mute is hard mute bit OR fault mute; release starts calibration.
`ifndef MGO_REGS_SVH
`define MGO_REGS_SVH

// Sub-addresses, alias bit already stripped
`define MGO_ADDR_MUTE_STAT 7'h00
`define MGO_ADDR_READBACK  7'h02
`define MGO_ADDR_VOL       7'h25
`define MGO_ADDR_HMUTE     7'h2c
`define MGO_ADDR_CAL_SEL   7'h2f
`define MGO_ADDR_FAULT     7'h3a
`define MGO_ADDR_POST_GAIN 7'h3b
`define MGO_ADDR_TRACK     7'h3d
`define MGO_ADDR_IRQ_STAT  7'h62
`define MGO_ADDR_IRQ_MASK  7'h63
`define MGO_ADDR_BANK      7'h70
`define MGO_NUM_CAL_BYTES  7'h08
`define MGO_NUM_VOL        7'h06

// Field positions
`define MGO_BIT_HMUTE      1
`define MGO_BIT_FMU        2
`define MGO_BIT_AUTO_REL   2
`define MGO_BIT_LATCH_CLR  1
`define MGO_BIT_TRACK      7
`define MGO_IRQ_CAL_DONE   0
`define MGO_IRQ_FAULT      1
`define MGO_IRQ_CAL_ABORT  2

// Reset values
`define MGO_HMUTE_RST      1'b1
`define MGO_VOL_RST        8'h00

// Pre-gain volume thresholds
`define MGO_VOL_FULL_MIN   8'hf4
`define MGO_VOL_HALF_MIN   8'he8
`define MGO_VOL_QUART_MIN  8'hdc

// Timing: one calibration level lasts at most this long
`define MGO_CLK_KHZ        125000
`define MGO_CAL_LEVEL_MS   1000
`define MGO_CAL_LEVEL_CYCLES (`MGO_CAL_LEVEL_MS * `MGO_CLK_KHZ)

`endif

// file: verilog/mgo_pkg.sv
// Types of the mute, gain and offset control block.
// Assumes six channels with ten-bit offsets.
package mgo_pkg;

  typedef enum logic [1:0] {MGO_PG_FULL, MGO_PG_HALF, MGO_PG_QUARTER, MGO_PG_EIGHTH}
    mgo_pregain_e;
  typedef enum logic {MGO_SEQ_IDLE, MGO_SEQ_RUN} mgo_seq_e;
  typedef logic [5:0][9:0] mgo_offs_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mgo_bus_s;

  typedef struct packed {
    logic drive_hi;
    logic drive_lo;
  } mgo_fault_s;

  typedef struct packed {
    mgo_seq_e    state;
    logic [31:0] cnt;
    logic [1:0]  level;
    logic        multi;
  } mgo_seq_s;

  typedef struct packed {
    logic [5:0][7:0]      vol;
    logic                 hard_mute_bit;
    logic                 fault_auto_release_enable;
    logic                 fault_latch_clear;
    logic                 volume_tracking_pregain;
    logic [5:0]           post_gain;
    logic [5:0]           calib_bank_select;
    mgo_offs_t            bank;
    logic [3:0][5:0][9:0] cal;
    logic                 fault_mute;
    logic                 mute_prev;
    mgo_pregain_e [5:0]   pregain;
    mgo_offs_t            offset;
    logic [2:0]           irq_stat;
    logic [2:0]           irq_mask;
    logic [7:0]           rd_data;
  } mgo_ctl_s;

endpackage : mgo_pkg

// file: verilog/mgo_pregain_map.sv
// Maps one channel volume to its pre-gain level.
// Assumes calibration level and busy come from the calibration sequencer.
`timescale 1ns/100ps
`include "mgo_regs.svh"
module mgo_pregain_map
(
  input  wire logic          ref_clk,
  input  wire logic          reset,
  input  wire logic [7:0]    vol,
  input  wire logic          volume_tracking_pregain,
  input  wire logic          cal_busy,
  input  wire logic [1:0]    cal_level,
  output mgo_pkg::mgo_pregain_e pregain
);
  import mgo_pkg::*;

  // Tracking off forces full gain; else calibration forces the level under test, otherwise the volume table
  always_comb
  begin
    if (!volume_tracking_pregain)
      pregain = MGO_PG_FULL;                   // R12
    else if (cal_busy)
      pregain = mgo_pregain_e'(cal_level);     // R08
    else if (vol >= `MGO_VOL_FULL_MIN)
      pregain = MGO_PG_FULL;                   // R13
    else if (vol >= `MGO_VOL_HALF_MIN)
      pregain = MGO_PG_HALF;
    else if (vol >= `MGO_VOL_QUART_MIN)
      pregain = MGO_PG_QUARTER;
    else
      pregain = MGO_PG_EIGHTH;
  end

  AST_TRACK_OFF_FULL: assert property (@(posedge ref_clk) disable iff (reset) // R12
    !volume_tracking_pregain |-> pregain == MGO_PG_FULL)
    else $error("pre-gain not full while tracking off");
  AST_VOL_TABLE: assert property (@(posedge ref_clk) disable iff (reset) // R13
    (volume_tracking_pregain && !cal_busy && vol < 8'hdc) |-> pregain == MGO_PG_EIGHTH)
    else $error("low volume did not select eighth gain");

endmodule : mgo_pregain_map

// file: verilog/mgo_cal_seq.sv
// Offset calibration sequencer: one or four timed levels per run.
// Assumes start and abort are single-clock decisions of the control core.
`timescale 1ns/100ps
`include "mgo_regs.svh"
module mgo_cal_seq #(
  parameter int unsigned LEVEL_CYCLES = `MGO_CAL_LEVEL_CYCLES
)
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       volume_tracking_pregain,
  output logic            busy,
  output logic [1:0]      level,
  output logic            store,
  output logic            done
);
  import mgo_pkg::*;

  mgo_seq_s st_r;
  mgo_seq_s st_nxt;

  // Level ends on the last cycle of its slot
  assign busy  = (st_r.state == MGO_SEQ_RUN);
  assign level = st_r.level;
  assign store = busy && (st_r.cnt == LEVEL_CYCLES - 1);
  assign done  = store && (!st_r.multi || st_r.level == 2'h3);

  // Mode is latched at start so a mid-run change cannot stretch the run
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r.state)
      MGO_SEQ_IDLE:
        if (start && !abort)
        begin
          st_nxt.state = MGO_SEQ_RUN;            // R06
          st_nxt.cnt   = 32'h0;
          st_nxt.level = 2'h0;
          st_nxt.multi = volume_tracking_pregain; // R08
        end
      MGO_SEQ_RUN:
        if (abort)
          st_nxt.state = MGO_SEQ_IDLE;
        else if (store)
        begin
          st_nxt.cnt = 32'h0;
          if (done)
            st_nxt.state = MGO_SEQ_IDLE;         // R07
          else
            st_nxt.level = st_r.level + 2'h1;    // R08
        end
        else
          st_nxt.cnt = st_r.cnt + 32'h1;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      st_r <= '{state: MGO_SEQ_IDLE, cnt: 32'h0, level: 2'h0, multi: 1'b0};
    else
      st_r <= st_nxt;
  end

  AST_CAL_SLOT_BOUND: assert property (@(posedge ref_clk) disable iff (reset) // R07
    busy |-> (st_r.cnt < LEVEL_CYCLES && (st_r.multi || st_r.level == 2'h0)))
    else $error("calibration slot overran");
  AST_FOUR_LEVELS: assert property (@(posedge ref_clk) disable iff (reset) // R08
    (store && st_r.multi && st_r.level != 2'h3 && !abort) |=> busy && level == $past(level) + 2'h1)
    else $error("calibration skipped a pre-gain level");

endmodule : mgo_cal_seq

// file: verilog/mgo_ctl.sv
// Mute, gain and offset control core: registers, fault mute, pre-gain,
// calibration storage and offset selection for six channels.
// Assumes a serial-bus front end that drives the plain register port and
// strips nothing: sub-addresses 80h-FFh mirror 00h-7Fh.
`timescale 1ns/100ps
`include "mgo_regs.svh"
module mgo_ctl #(
  parameter int unsigned CAL_LEVEL_CYCLES = `MGO_CAL_LEVEL_CYCLES
)
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              reset_pin_active_low,
  input  wire mgo_pkg::mgo_bus_s bus,
  output logic [7:0]             rd_data,
  input  wire mgo_pkg::mgo_fault_s fault,
  input  wire mgo_pkg::mgo_offs_t offset_meas,
  output logic                   hard_mute,
  output mgo_pkg::mgo_pregain_e [5:0] pregain,
  output logic [5:0]             post_gain_high,
  output mgo_pkg::mgo_offs_t     offset_out,
  output logic                   cal_busy,
  output logic                   irq
);
  import mgo_pkg::*;

  // Packs six ten-bit values into the eight-byte readback layout
  function automatic logic [7:0] mgo_cal_rd(input mgo_offs_t v, input logic [2:0] i);
    logic [2:0] b;
    b = i[2] ? 3'h3 : 3'h0;
    if (i[1:0] == 2'h3)
      return {2'b00, v[b + 3'h2][1:0], v[b + 3'h1][1:0], v[b][1:0]};
    return v[b + {1'b0, i[1:0]}][9:2];
  endfunction : mgo_cal_rd

  // Inverse of the readback packing, for the bank registers
  function automatic mgo_offs_t mgo_cal_wr(input mgo_offs_t v, input logic [2:0] i,
                                           input logic [7:0] d);
    mgo_offs_t  r;
    logic [2:0] b;
    r = v;
    b = i[2] ? 3'h3 : 3'h0;
    if (i[1:0] == 2'h3)
    begin
      r[b][1:0]        = d[1:0];
      r[b + 3'h1][1:0] = d[3:2];
      r[b + 3'h2][1:0] = d[5:4];
    end
    else
      r[b + {1'b0, i[1:0]}][9:2] = d;
    return r;
  endfunction : mgo_cal_wr

  // Default state of every register the reset pin touches
  function automatic mgo_ctl_s mgo_ctl_rst();
    mgo_ctl_s r;
    r = '0;
    r.hard_mute_bit = `MGO_HMUTE_RST;
    r.mute_prev     = `MGO_HMUTE_RST;
    for (int c = 0; c < 6; c++)
    begin
      r.vol[c]     = `MGO_VOL_RST;
      r.pregain[c] = MGO_PG_FULL;
    end
    return r;
  endfunction : mgo_ctl_rst

  localparam mgo_ctl_s CTL_RST = mgo_ctl_rst();

  mgo_ctl_s            st_r;
  mgo_ctl_s            st_nxt;
  logic [6:0]          addr;
  logic                fault_active;
  logic                latch_clr_rise;
  logic                mute_comb;
  logic                cal_start;
  logic                cal_abort;
  logic                seq_store;
  logic                seq_done;
  logic [1:0]          seq_level;
  mgo_offs_t           cal_use;
  mgo_pregain_e [5:0]  pg_map;
  logic [2:0]          irq_ev;

  // Upper half of the sub-address space mirrors the lower half
  assign addr = bus.addr[6:0];

  // Either driven level on the fault pin means a fault
  assign fault_active = fault.drive_hi | fault.drive_lo;                    // R03

  // Latch clear acts on a written zero-to-one change only
  assign latch_clr_rise = bus.wr && addr == `MGO_ADDR_FAULT
                          && bus.wdata[`MGO_BIT_LATCH_CLR] && !st_r.fault_latch_clear;

  // Effective mute and the release that starts calibration
  assign mute_comb = st_r.hard_mute_bit | st_r.fault_mute;                  // R19
  assign cal_start = st_r.mute_prev & ~mute_comb;                           // R06
  assign cal_abort = mute_comb | ~reset_pin_active_low;

  // Offsets in use per channel follow that channel's pre-gain
  always_comb
  begin
    for (int c = 0; c < 6; c++)
      cal_use[c] = st_r.cal[st_r.pregain[c]][c];                            // R10
  end

  mgo_cal_seq #(
    .LEVEL_CYCLES (CAL_LEVEL_CYCLES)
  ) u_seq (
    .ref_clk (ref_clk),
    .reset   (reset),
    .start   (cal_start),
    .abort   (cal_abort),
    .volume_tracking_pregain (st_r.volume_tracking_pregain),
    .busy    (cal_busy),
    .level   (seq_level),
    .store   (seq_store),
    .done    (seq_done)
  );

  // One pre-gain map per channel
  for (genvar g = 0; g < 6; g++)
  begin : g_pg
    mgo_pregain_map u_map (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .vol       (st_r.vol[g]),
      .volume_tracking_pregain (st_r.volume_tracking_pregain),
      .cal_busy  (cal_busy),
      .cal_level (seq_level),
      .pregain   (pg_map[g])
    );
  end

  // Interrupt events: calibration end, fault mute entry, aborted calibration
  always_comb
  begin
    irq_ev                     = 3'h0;
    irq_ev[`MGO_IRQ_CAL_DONE]  = seq_done && !cal_abort;
    irq_ev[`MGO_IRQ_FAULT]     = fault_active && !st_r.fault_mute;
    irq_ev[`MGO_IRQ_CAL_ABORT] = cal_busy && cal_abort;
  end

  // Next-state: register writes, reads, fault, calibration and outputs
  always_comb
  begin
    st_nxt = st_r;
    // Register writes
    if (bus.wr)
    begin
      if (addr >= `MGO_ADDR_VOL && addr < `MGO_ADDR_VOL + `MGO_NUM_VOL)
        st_nxt.vol[3'(addr - `MGO_ADDR_VOL)] = bus.wdata;
      else if (addr >= `MGO_ADDR_BANK && addr < `MGO_ADDR_BANK + `MGO_NUM_CAL_BYTES)
        st_nxt.bank = mgo_cal_wr(st_r.bank, 3'(addr - `MGO_ADDR_BANK), bus.wdata);
      else
        unique case (addr)
          `MGO_ADDR_HMUTE:     st_nxt.hard_mute_bit = bus.wdata[`MGO_BIT_HMUTE];
          `MGO_ADDR_CAL_SEL:   st_nxt.calib_bank_select = bus.wdata[5:0];
          `MGO_ADDR_FAULT:
          begin
            st_nxt.fault_auto_release_enable = bus.wdata[`MGO_BIT_AUTO_REL];
            st_nxt.fault_latch_clear         = bus.wdata[`MGO_BIT_LATCH_CLR];
          end
          `MGO_ADDR_POST_GAIN: st_nxt.post_gain = bus.wdata[5:0];                  // R14
          `MGO_ADDR_TRACK:
            st_nxt.volume_tracking_pregain = bus.wdata[`MGO_BIT_TRACK];            // R11
          `MGO_ADDR_IRQ_MASK:  st_nxt.irq_mask = bus.wdata[2:0];
          default:             st_nxt.vol = st_r.vol;
        endcase
    end
    // Sticky status: write one clears, a same-cycle event still sets
    if (bus.wr && addr == `MGO_ADDR_IRQ_STAT)
      st_nxt.irq_stat = st_r.irq_stat & ~bus.wdata[2:0];
    st_nxt.irq_stat = st_nxt.irq_stat | irq_ev;
    // Read data, valid only in the cycle after the strobe
    st_nxt.rd_data = 8'h00;
    if (bus.rd)
    begin
      if (addr >= `MGO_ADDR_READBACK && addr < `MGO_ADDR_READBACK + `MGO_NUM_CAL_BYTES)
        st_nxt.rd_data = mgo_cal_rd(cal_use, 3'(addr - `MGO_ADDR_READBACK));     // R09
      else if (addr >= `MGO_ADDR_BANK && addr < `MGO_ADDR_BANK + `MGO_NUM_CAL_BYTES)
        st_nxt.rd_data = mgo_cal_rd(st_r.bank, 3'(addr - `MGO_ADDR_BANK));
      else if (addr >= `MGO_ADDR_VOL && addr < `MGO_ADDR_VOL + `MGO_NUM_VOL)
        st_nxt.rd_data = st_r.vol[3'(addr - `MGO_ADDR_VOL)];
      else
        unique case (addr)
          `MGO_ADDR_MUTE_STAT:
          begin
            st_nxt.rd_data[`MGO_BIT_FMU]   = st_r.fault_mute;
            st_nxt.rd_data[`MGO_BIT_HMUTE] = mute_comb;
          end
          `MGO_ADDR_HMUTE:     st_nxt.rd_data[`MGO_BIT_HMUTE] = st_r.hard_mute_bit;
          `MGO_ADDR_CAL_SEL:   st_nxt.rd_data = {2'b00, st_r.calib_bank_select};
          `MGO_ADDR_FAULT:
          begin
            st_nxt.rd_data[`MGO_BIT_AUTO_REL]  = st_r.fault_auto_release_enable;
            st_nxt.rd_data[`MGO_BIT_LATCH_CLR] = st_r.fault_latch_clear;
          end
          `MGO_ADDR_POST_GAIN: st_nxt.rd_data = {2'b00, st_r.post_gain};
          `MGO_ADDR_TRACK:
            st_nxt.rd_data[`MGO_BIT_TRACK] = st_r.volume_tracking_pregain;
          `MGO_ADDR_IRQ_STAT:  st_nxt.rd_data = {5'h00, st_r.irq_stat};
          `MGO_ADDR_IRQ_MASK:  st_nxt.rd_data = {5'h00, st_r.irq_mask};
          default:             st_nxt.rd_data = 8'h00;
        endcase
    end
    // Fault mute: pin wins over any release in the same cycle
    if (fault_active)
      st_nxt.fault_mute = 1'b1;                                               // R03
    else if (st_r.fault_auto_release_enable)
      st_nxt.fault_mute = 1'b0;                                               // R04
    else if (latch_clr_rise)
      st_nxt.fault_mute = 1'b0;                                               // R05
    st_nxt.mute_prev = mute_comb;
    // Store the measured offset at the end of each calibration level
    if (seq_store && !cal_abort)
      for (int c = 0; c < 6; c++)
        st_nxt.cal[seq_level][c] = offset_meas[c];                            // R09
    // Registered pre-gain and selected offset per channel
    for (int c = 0; c < 6; c++)
    begin
      st_nxt.pregain[c] = pg_map[c];                                          // R11
      st_nxt.offset[c]  = st_r.calib_bank_select[c] ? st_r.bank[c] : cal_use[c]; // R15
    end
    // Reset pin clears all but the bank, which sits in the kept range
    if (!reset_pin_active_low)
    begin
      st_nxt      = CTL_RST;                                                  // R01
      st_nxt.bank = st_r.bank;                                                // R02
    end
  end

  // Power-on reset clears the bank too, so it never starts unknown
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      st_r <= CTL_RST;
    else
      st_r <= st_nxt;
  end

  // Outputs
  assign rd_data        = st_r.rd_data;
  assign hard_mute      = mute_comb;
  assign pregain        = st_r.pregain;
  assign post_gain_high = st_r.post_gain;                                     // R14
  assign offset_out     = st_r.offset;
  assign irq            = |(st_r.irq_stat & st_r.irq_mask);

  AST_RESET_PIN_DEFAULTS: assert property (@(posedge ref_clk) disable iff (reset) // R01
    !reset_pin_active_low |=> (hard_mute && st_r.vol == '0 && st_r.calib_bank_select == 6'h00
                               && !st_r.volume_tracking_pregain))
    else $error("reset pin did not restore defaults");
  AST_BANK_KEPT: assert property (@(posedge ref_clk) disable iff (reset) // R02
    !reset_pin_active_low |=> st_r.bank == $past(st_r.bank))
    else $error("bank changed under reset pin");
  AST_FAULT_MUTES: assert property (@(posedge ref_clk) disable iff (reset) // R03
    (fault_active && reset_pin_active_low) |=> (st_r.fault_mute && hard_mute))
    else $error("fault pin did not mute");
  AST_AUTO_RELEASE: assert property (@(posedge ref_clk) disable iff (reset) // R04
    (st_r.fault_mute && !fault_active && st_r.fault_auto_release_enable) |=> !st_r.fault_mute)
    else $error("auto-release did not unmute");
  AST_LATCH_HOLD: assert property (@(posedge ref_clk) disable iff (reset) // R05
    (st_r.fault_mute && !st_r.fault_auto_release_enable && !latch_clr_rise
     && reset_pin_active_low) |=> st_r.fault_mute)
    else $error("latched fault mute released early");
  AST_UNMUTE_CALIBRATES: assert property (@(posedge ref_clk) disable iff (reset) // R06
    ($fell(hard_mute) && reset_pin_active_low) ##1 !hard_mute |-> cal_busy)
    else $error("unmute did not start calibration");
  AST_BANK_SELECT: assert property (@(posedge ref_clk) disable iff (reset) // R15
    (st_r.calib_bank_select[0] && reset_pin_active_low) |=> offset_out[0] == $past(st_r.bank[0]))
    else $error("bank value not used when selected");
  AST_READBACK_LEVEL: assert property (@(posedge ref_clk) disable iff (reset) // R10
    (bus.rd && addr == `MGO_ADDR_READBACK && reset_pin_active_low)
      |=> rd_data == $past(st_r.cal[st_r.pregain[0]][0][9:2]))
    else $error("readback not tied to selected pre-gain");
  AST_POST_GAIN: assert property (@(posedge ref_clk) disable iff (reset) // R14
    (bus.wr && addr == `MGO_ADDR_POST_GAIN && reset_pin_active_low)
      |=> post_gain_high == $past(bus.wdata[5:0]))
    else $error("post-gain select not applied");

endmodule : mgo_ctl

// file: test/mgo_far_end.sv
// Far-side model: fault pin source and per-channel offset measurement.
// Assumes the bench picks the fault pin level through fault_sel.
`timescale 1ns/100ps
module mgo_far_end
  import mgo_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic [1:0]     fault_sel,
  output mgo_pkg::mgo_fault_s fault,
  output mgo_pkg::mgo_offs_t  offset_meas
);
  // Pin level changes just after an edge: 0 floating, 1 high, 2 low
  always_ff @(posedge ref_clk)
  begin
    fault <= '{drive_hi: (fault_sel == 2'h1), drive_lo: (fault_sel == 2'h2)};
  end

  // Fixed measured offset: the same code on every channel keeps checks simple
  assign offset_meas = {6{10'h2a5}};
endmodule : mgo_far_end

// file: test/mute_gain_offset_control_bench.sv
// Self-checking bench for the mute, gain and offset control core.
// Assumes the far-side model in mgo_far_end and a short calibration level.
`timescale 1ns/100ps
module mute_gain_offset_control_bench;
  import mgo_pkg::*;
  localparam int LEV = 20;
  logic                ref_clk, reset, pin_n, irq, hard_mute, cal_busy;
  logic [1:0]          fsel;
  logic [7:0]          rd_data, d;
  logic [5:0]          post_gain_high;
  mgo_bus_s            bus;
  mgo_fault_s          fault;
  mgo_offs_t           meas, offset_out;
  mgo_pregain_e [5:0]  pregain;
  int                  num_errors, n_checks, cyc, c;

  mgo_ctl #(.CAL_LEVEL_CYCLES(LEV)) dut (.ref_clk(ref_clk), .reset(reset),
    .reset_pin_active_low(pin_n), .bus(bus), .rd_data(rd_data), .fault(fault),
    .offset_meas(meas), .hard_mute(hard_mute), .pregain(pregain),
    .post_gain_high(post_gain_high), .offset_out(offset_out), .cal_busy(cal_busy), .irq(irq));
  mgo_far_end far (.ref_clk(ref_clk), .fault_sel(fsel), .fault(fault), .offset_meas(meas));

  // Clock and hang guard; the ceiling is far above the planned run
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      $display("MISMATCH %0t run timed out", $time);
      conclude();
    end
  end

  // Shared helpers; strobes drop right after the taking edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus <= '{1'b1, 1'b0, a, v};
    @(posedge ref_clk);
    bus <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    bus <= '0;
    #1 d = rd_data;
  endtask : rd
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string w);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask : chk
  // Unmute and count busy cycles, both waits bounded
  task automatic run_cal(output int n);
    int w;
    w = 0;
    n = 0;
    wr(8'h2c, 8'h00);
    while (cal_busy !== 1'b1 && w < 10)
    begin
      tick(1);
      w++;
    end
    while (cal_busy === 1'b1 && n < 200)
    begin
      tick(1);
      n++;
    end
  endtask : run_cal

  task automatic t_reset;
    chk(hard_mute, 1, "mute after reset");
    rd(8'h2c);
    chk(d[1], 1, "mute bit default");
    chk(pregain[0], MGO_PG_FULL, "pregain default");
    $display("test reset done");
  endtask : t_reset

  task automatic t_pin;
    wr(8'h25, 8'hf0);
    wr(8'h70, 8'h5a);
    pin_n <= 1'b0;
    tick(1);
    pin_n <= 1'b1;
    tick(1);
    rd(8'h25);
    chk(d, 8'h00, "volume not defaulted");
    rd(8'h70);
    chk(d, 8'h5a, "bank lost");
    rd(8'hf0);
    chk(d, 8'h5a, "bank mirror lost");
    $display("test reset pin done");
  endtask : t_pin

  task automatic t_pgain;
    logic [7:0] vt [8];
    logic [1:0] pt [8];
    vt = '{8'hff, 8'hf4, 8'hf3, 8'he8, 8'he7, 8'hdc, 8'hdb, 8'h00};
    pt = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
    wr(8'h25, 8'he7);
    tick(2);
    chk(pregain[0], MGO_PG_FULL, "pregain not full");
    wr(8'h3d, 8'h80);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h25, vt[i]);
      tick(2);
      chk(pregain[0], pt[i], "pregain table");
    end
    wr(8'h3b, 8'h00);
    wr(8'h3d, 8'h00);
    $display("test pregain done");
  endtask : t_pgain

  task automatic t_post;
    wr(8'h3b, 8'h3f);
    tick(1);
    chk(post_gain_high, 6'h3f, "post gain high");
    wr(8'h3b, 8'h15);
    tick(1);
    chk(post_gain_high, 6'h15, "post gain mix");
    wr(8'h3b, 8'h00);
    $display("test post gain done");
  endtask : t_post

  task automatic t_cal;
    wr(8'h63, 8'h07);
    run_cal(c);
    chk(c >= LEV - 1 && c <= LEV + 1, 1, "single level length");
    chk(irq, 1, "done irq");
    wr(8'h62, 8'h01);
    tick(1);
    chk(irq, 0, "irq not cleared");
    rd(8'h02);
    chk(d, 8'ha9, "readback msb");
    rd(8'h05);
    chk(d, 8'h15, "readback lsb");
    wr(8'h2c, 8'h02);
    wr(8'h3d, 8'h80);
    run_cal(c);
    chk(c > 3 * LEV && c <= 4 * LEV + 4, 1, "four level length");
    wr(8'h2c, 8'h02);
    wr(8'h3d, 8'h00);
    $display("test calibration done");
  endtask : t_cal

  task automatic t_fault;
    run_cal(c);
    wr(8'h3a, 8'h04);
    fsel <= 2'h1;
    tick(3);
    chk(hard_mute, 1, "fault high no mute");
    rd(8'h00);
    chk(d[2], 1, "fault mute status");
    rd(8'h62);
    chk(d[1], 1, "fault irq status");
    fsel <= 2'h0;
    tick(3);
    chk(hard_mute, 0, "no auto release");
    tick(30);
    wr(8'h3a, 8'h00);
    fsel <= 2'h2;
    tick(3);
    chk(hard_mute, 1, "fault low no mute");
    fsel <= 2'h0;
    tick(3);
    chk(hard_mute, 1, "latch released early");
    wr(8'h3a, 8'h02);
    tick(2);
    chk(hard_mute, 0, "latch clear ignored");
    chk(cal_busy, 1, "no calibration on release");
    tick(30);
    $display("test fault done");
  endtask : t_fault

  task automatic t_bank;
    wr(8'h3a, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      rd(8'h02 + 8'(i));
      wr(8'h70 + 8'(i), d);
    end
    tick(2);
    chk(offset_out[0], 10'h2a5, "internal offset");
    wr(8'h70, 8'h12);
    wr(8'h73, 8'h03);
    wr(8'h2f, 8'h01);
    tick(2);
    chk(offset_out[0], 10'h04b, "bank offset");
    wr(8'h2f, 8'h00);
    tick(2);
    chk(offset_out[0], 10'h2a5, "back to internal");
    $display("test bank done");
  endtask : t_bank

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // Main sequence
  initial
  begin
    reset = 1'b1;
    pin_n = 1'b1;
    fsel = 2'h0;
    bus = '0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    tick(1);
    t_reset();
    t_pin();
    t_pgain();
    t_post();
    t_cal();
    t_fault();
    t_bank();
    conclude();
  end
endmodule : mute_gain_offset_control_bench
